// ---- test/memory_map_banking_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module memory_map_banking_tb_top;
  reg core_clk = 0, rst = 1, pc_advance = 0, pc_load = 0, int_accept = 0, d_req = 0, d_we = 0;
  reg [1:0] bank = 0;
  reg [12:0] pc_target = 0;
  reg [6:0] d_ofs = 0;
  reg [7:0] d_wdata = 0;
  wire [7:0] status, ram_rdata;
  wire [12:0] pc_q;
  wire [10:0] pm_addr_q;
  wire [8:0] d_addr_q, sfr_addr_q;
  wire d_sfr_q, d_ram_q, d_unimp_q;
  int bad_count = 0, cmp_count = 0;
  mmb_core_model core (.*);
  mmb_memory_map uut (.*);
  initial forever #2.5 core_clk = ~core_clk;
  task give_verdict;
    $display("cmp %0d bad %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task dat(input [1:0] b, input w, input [6:0] o, input [7:0] v);
    @(posedge core_clk) {bank, d_req, d_we, d_ofs, d_wdata} <= {b, 1'b1, w, o, v};
    @(posedge core_clk) {d_req, d_we} <= 2'h0;
    #1;
  endtask
  task t_fetch;
    `CHK(pc_q, 13'h0000)
    @(posedge core_clk) {pc_load, pc_target} <= {1'b1, 13'h07ff};
    @(posedge core_clk) {pc_load, pc_advance} <= 2'h1;
    @(posedge core_clk) {pc_advance, int_accept} <= 2'h1;
    #1 `CHK({pc_q, pm_addr_q}, {13'h0800, 11'h000})
    @(posedge core_clk) {int_accept, rst} <= 2'h1;
    #1 `CHK(pc_q, 13'h0004)
    @(posedge core_clk) rst <= 0;
    #1 `CHK(pc_q, 13'h0000)
    $display("fetch done");
  endtask
  task t_data;
    dat(2'h0, 1'b1, 7'h75, 8'ha5);
    dat(2'h1, 1'b0, 7'h75, 8'h00);
    `CHK({d_ram_q, d_addr_q, ram_rdata}, {1'b1, 9'h0f5, 8'ha5})
    dat(2'h1, 1'b1, 7'h25, 8'h3c);
    dat(2'h0, 1'b1, 7'h25, 8'hc3);
    dat(2'h2, 1'b1, 7'h25, 8'h77);
    `CHK({d_unimp_q, d_ram_q}, 2'h2)
    dat(2'h1, 1'b0, 7'h25, 8'h00);
    `CHK({d_addr_q, ram_rdata}, {9'h0a5, 8'h3c})
    dat(2'h1, 1'b0, 7'h03, 8'h00);
    `CHK({d_sfr_q, sfr_addr_q}, {1'b1, 9'h003})
    $display("data done");
  endtask
  task t_shared;
    dat(2'h0, 1'b1, 7'h70, 8'h11);
    dat(2'h1, 1'b1, 7'h20, 8'h22);
    dat(2'h1, 1'b1, 7'h7f, 8'h33);
    dat(2'h0, 1'b0, 7'h70, 8'h00);
    `CHK(ram_rdata, 8'h11)
    dat(2'h1, 1'b0, 7'h20, 8'h00);
    `CHK({d_ram_q, ram_rdata}, {1'b1, 8'h22})
    dat(2'h0, 1'b0, 7'h7f, 8'h00);
    `CHK({d_addr_q, ram_rdata}, {9'h07f, 8'h33})
    dat(2'h1, 1'b1, 7'h45, 8'h44);
    `CHK({d_ram_q, d_sfr_q}, 2'h0)
    dat(2'h0, 1'b0, 7'h1f, 8'h00);
    `CHK({d_sfr_q, d_ram_q}, 2'h2)
    dat(2'h1, 1'b0, 7'h01, 8'h00);
    `CHK(sfr_addr_q, 9'h081)
    dat(2'h3, 1'b1, 7'h70, 8'h55);
    `CHK({d_unimp_q, d_ram_q, d_sfr_q}, 3'h4)
    dat(2'h0, 1'b0, 7'h70, 8'h00);
    `CHK(ram_rdata, 8'h11)
    $display("shared done");
  endtask
  task t_both;
    @(posedge core_clk) {pc_advance, bank, d_req, d_ofs} <= {1'b1, 2'h0, 1'b1, 7'h7f};
    @(posedge core_clk) {pc_advance, d_req} <= 2'h0;
    #1 `CHK({pc_q, pm_addr_q, d_ram_q, ram_rdata}, {13'h0001, 11'h001, 1'b1, 8'h33})
    $display("both done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk) #1 t_fetch;
    t_data;
    t_shared;
    t_both;
    give_verdict;
  end
  initial begin
    repeat (400) @(posedge core_clk);
    bad_count++;
    give_verdict;
  end
endmodule

// ---- test/mmb_core_model.sv ----
`timescale 1ns/1ps
module mmb_core_model (
  input  wire [1:0] bank,   // bank wanted by the test
  output wire [7:0] status  // status value seen by the map
);
  assign status = {1'b1, bank, 5'h1b};
endmodule

// ---- test/mmb_map_sva.sv ----
`timescale 1ns/1ps
module mmb_map_sva (
  input wire        core_clk,   // core clock
  input wire        rst,        // sync reset
  input wire        pc_advance, // step request
  input wire        pc_load,    // jump request
  input wire        int_accept, // interrupt taken
  input wire        d_req,      // data access
  input wire        d_sfr_q,    // sfr hit
  input wire        d_ram_q,    // ram hit
  input wire        d_unimp_q,  // missing bank
  input wire [12:0] pc_q,       // program counter
  input wire [10:0] pm_addr_q,  // program word index
  input wire [7:0]  status,     // bank select source
  input wire [6:0]  d_ofs,      // in-bank offset
  input wire [8:0]  d_addr_q,   // full data address
  input wire [8:0]  sfr_addr_q  // sfr address after mirroring
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_pc: assert property (disable iff (1'b0) rst |=> pc_q == 13'h0)
    else $error("reset pc");
  a_int_vec: assert property (int_accept |=> pc_q == 13'h4) else $error("int pc");
  a_pc_step: assert property (pc_advance && !pc_load && !int_accept |=>
    pc_q == $past(pc_q) + 13'h1) else $error("pc step");
  a_pm_wrap: assert property (pm_addr_q == pc_q[10:0]) else $error("pm wrap");
  a_bank_addr: assert property (1'b1 |=>
    d_addr_q == {$past(status[6:5]), $past(d_ofs)}) else $error("addr");
  a_bank_none: assert property (1'b1 |=>
    d_unimp_q == ($past(d_req) && $past(status[6]))) else $error("unimp");
  a_sfr_hit: assert property (d_req && !status[6] && d_ofs < 7'h20 |=> d_sfr_q)
    else $error("sfr");
  a_ram_hit: assert property (d_req && !status[6] && d_ofs[6:5] == 2'h1 |=> d_ram_q)
    else $error("ram");
  a_b1_gap: assert property (d_req && status[6:5] == 2'h1 && d_ofs >= 7'h40 &&
    d_ofs < 7'h70 |=> !d_ram_q && !d_sfr_q) else $error("bank1 gap");
  a_sfr_mirror: assert property (d_req && status[6:5] == 2'h1 && d_ofs == 7'h03
    |=> sfr_addr_q == 9'h003) else $error("sfr mirror");
  c_bank3: cover property (d_req && status[6:5] == 2'h3);
  c_int: cover property (int_accept);
  c_shared: cover property (d_req && status[5] && d_ofs > 7'h6f);
  c_unimp: cover property (d_unimp_q);
endmodule
bind mmb_memory_map mmb_map_sva u_sva (.*);

// ---- verilog/mmb_gpr_ram.v ----
`timescale 1ns/1ps
`include "mmb_map.vh"

module mmb_gpr_ram (
  input  wire                      core_clk, // core clock
  input  wire                      we,       // write strobe
  input  wire [`MMB_RAM_AW-1:0]    waddr,    // write index
  input  wire [`MMB_DATA_W-1:0]    wdata,    // write data
  input  wire [`MMB_RAM_AW-1:0]    raddr,    // read index
  output reg  [`MMB_DATA_W-1:0]    rdata     // registered read data
);
  reg [`MMB_DATA_W-1:0] mem [0:`MMB_RAM_WORDS-1];

  always @(posedge core_clk) begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule

// ---- verilog/mmb_map.vh ----
`ifndef MMB_MAP_VH
`define MMB_MAP_VH

`define MMB_PC_W          13
`define MMB_PM_AW         11
`define MMB_PM_WORDS      2048
`define MMB_INSN_W        14
`define MMB_RESET_VEC     13'h0000
`define MMB_INT_VEC       13'h0004
`define MMB_STATUS_W      8
`define MMB_BSEL_HI_BIT   6
`define MMB_BSEL_LO_BIT   5
`define MMB_OFS_W         7
`define MMB_ADDR_W        9
`define MMB_BANK0         2'h0
`define MMB_BANK1         2'h1
`define MMB_SFR_TOP       7'h1f
`define MMB_SHARED_BASE   7'h70
`define MMB_B1_GPR_TOP    7'h3f
`define MMB_RAM_AW        7
`define MMB_RAM_WORDS     128
`define MMB_B1_RAM_BASE   7'h60
`define MMB_DATA_W        8
`define MMB_GPR_BASE      7'h20
`define MMB_BANK_ONE      4'h1
`define MMB_BANK_PRESENT  4'h3
`define MMB_BANK_COUNT    4
`define MMB_MIR_INDIRECT  7'h00
`define MMB_MIR_PC_LOW    7'h02
`define MMB_MIR_STATUS    7'h03
`define MMB_MIR_POINTER   7'h04
`define MMB_MIR_PC_LATCH  7'h0a
`define MMB_MIR_INT_CTRL  7'h0b

`endif

// ---- verilog/mmb_memory_map.v ----
`timescale 1ns/1ps
`include "mmb_map.vh"

// Contract
// - separate program and data buses, concurrent
// - thirteen bit program counter, 8K space
// - 2K words implemented; higher addresses wrap
// - any reset starts fetch at zero
// - accepted interrupt loads PC with four
// - status bits six:five select data bank
// - each bank spans offsets 0 to 7f
// - low offsets special registers, then ram
// - top sixteen ram bytes shared, six bank 1 sfrs mirrored to bank 0
module mmb_memory_map (
  input  wire                      core_clk,    // core clock
  input  wire                      rst,         // sync reset, active high
  input  wire                      pc_advance,  // step pc to next word
  input  wire                      pc_load,     // jump request
  input  wire [`MMB_PC_W-1:0]      pc_target,   // jump destination
  input  wire                      int_accept,  // interrupt taken
  output reg  [`MMB_PC_W-1:0]      pc_q,        // program counter
  output reg  [`MMB_PM_AW-1:0]     pm_addr_q,   // physical program word index
  input  wire [`MMB_STATUS_W-1:0]  status,      // status register value
  input  wire                      d_req,       // data access request
  input  wire                      d_we,        // data write
  input  wire [`MMB_OFS_W-1:0]     d_ofs,       // in-bank offset from opcode
  input  wire [`MMB_DATA_W-1:0]    d_wdata,     // write data
  output reg  [`MMB_ADDR_W-1:0]    d_addr_q,    // full data address
  output reg                       d_sfr_q,     // access hits special function space
  output reg  [`MMB_ADDR_W-1:0]    sfr_addr_q,  // sfr address after mirroring
  output reg                       d_ram_q,     // access hits general ram
  output reg                       d_unimp_q,   // access to missing bank
  output wire [`MMB_DATA_W-1:0]    ram_rdata    // general ram read data, registered
);
  wire [1:0]               bank;
  wire [3:0]               bank_sel;
  wire [3:0]               bank_impl;
  wire                     bank_ok;
  reg  [`MMB_PC_W-1:0]     pc_d;
  reg  [`MMB_RAM_AW-1:0]   ram_idx;
  reg                      ram_hit;
  reg                      ram_we;
  reg  [`MMB_ADDR_W-1:0]   d_addr_d;
  reg                      d_sfr_d;
  reg  [`MMB_ADDR_W-1:0]   sfr_addr_d;
  reg                      d_ram_d;
  reg                      d_unimp_d;

  localparam [3:0] BANK_PRESENT = `MMB_BANK_PRESENT;

  assign bank = {status[`MMB_BSEL_HI_BIT], status[`MMB_BSEL_LO_BIT]};

  // one-hot view of the selected bank
  assign bank_sel = `MMB_BANK_ONE << bank;

  // per-bank flag, set only for the selected bank when it is present
  genvar gi;
  generate
    for (gi = 0; gi < `MMB_BANK_COUNT; gi = gi + 1) begin : g_bank
      assign bank_impl[gi] = bank_sel[gi] & BANK_PRESENT[gi];
    end
  endgenerate

  assign bank_ok = |bank_impl;

  // bank 1 sfrs that are the same registers as in bank 0
  function is_mirrored;
    input [`MMB_OFS_W-1:0] ofs;
    begin
      case (ofs)
        `MMB_MIR_INDIRECT,
        `MMB_MIR_PC_LOW,
        `MMB_MIR_STATUS,
        `MMB_MIR_POINTER,
        `MMB_MIR_PC_LATCH,
        `MMB_MIR_INT_CTRL: is_mirrored = 1'b1;
        default:           is_mirrored = 1'b0;
      endcase
    end
  endfunction

  // offset lies in the special function space
  function in_sfr_space;
    input [`MMB_OFS_W-1:0] ofs;
    begin
      in_sfr_space = (ofs <= `MMB_SFR_TOP);
    end
  endfunction

  // offset lies in the ram window common to banks 0 and 1
  function in_shared;
    input [`MMB_OFS_W-1:0] ofs;
    begin
      in_shared = (ofs >= `MMB_SHARED_BASE);
    end
  endfunction

  // offset lies in the private ram of bank 1
  function in_b1_ram;
    input [`MMB_OFS_W-1:0] ofs;
    begin
      in_b1_ram = !in_sfr_space(ofs) && (ofs <= `MMB_B1_GPR_TOP);
    end
  endfunction

  // ram slot counted from the first ram offset of a bank
  function [`MMB_RAM_AW-1:0] gpr_slot;
    input [`MMB_OFS_W-1:0] ofs;
    begin
      gpr_slot = ofs - `MMB_GPR_BASE;
    end
  endfunction

  // address handed to the sfr file once bank 1 mirroring is applied
  function [`MMB_ADDR_W-1:0] sfr_target;
    input [1:0]            bsel;
    input [`MMB_OFS_W-1:0] ofs;
    begin
      if ((bsel == `MMB_BANK1) && is_mirrored(ofs))
        sfr_target = {`MMB_BANK0, ofs};
      else
        sfr_target = {bsel, ofs};
    end
  endfunction

  // program counter path
  always @* begin
    pc_d = pc_q;
    if (int_accept)
      pc_d = `MMB_INT_VEC;
    else if (pc_load)
      pc_d = pc_target;
    else if (pc_advance)
      pc_d = pc_q + {{(`MMB_PC_W-1){1'b0}}, 1'b1};
  end

  always @(posedge core_clk) begin
    if (rst) begin
      pc_q      <= `MMB_RESET_VEC;
      pm_addr_q <= {`MMB_PM_AW{1'b0}};
    end else begin
      pc_q      <= pc_d;
      pm_addr_q <= pc_d[`MMB_PM_AW-1:0];
    end
  end

  // data decode, independent of the fetch path
  always @* begin
    ram_hit = 1'b0;
    ram_idx = {`MMB_RAM_AW{1'b0}};
    if (bank_ok && !in_sfr_space(d_ofs)) begin
      if (in_shared(d_ofs)) begin
        ram_hit = 1'b1;
        ram_idx = gpr_slot(d_ofs);
      end else if (bank == `MMB_BANK0) begin
        ram_hit = 1'b1;
        ram_idx = gpr_slot(d_ofs);
      end else if (in_b1_ram(d_ofs)) begin
        ram_hit = 1'b1;
        ram_idx = gpr_slot(d_ofs) + `MMB_B1_RAM_BASE;
      end
    end
  end

  // write only when the access lands in implemented ram
  always @* begin
    ram_we = d_req && d_we && ram_hit;
  end

  // next values of the registered data-side outputs
  always @* begin
    d_addr_d   = {bank, d_ofs};
    d_sfr_d    = d_req && bank_ok && in_sfr_space(d_ofs);
    sfr_addr_d = sfr_target(bank, d_ofs);
    d_ram_d    = d_req && ram_hit;
    d_unimp_d  = d_req && !bank_ok;
  end

  // registered data-side outputs
  always @(posedge core_clk) begin
    if (rst) begin
      d_addr_q <= {`MMB_ADDR_W{1'b0}};
    end else begin
      d_addr_q <= d_addr_d;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      d_sfr_q <= 1'b0;
      d_ram_q <= 1'b0;
    end else begin
      d_sfr_q <= d_sfr_d;
      d_ram_q <= d_ram_d;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      d_unimp_q <= 1'b0;
    end else begin
      d_unimp_q <= d_unimp_d;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      sfr_addr_q <= {`MMB_ADDR_W{1'b0}};
    end else begin
      sfr_addr_q <= sfr_addr_d;
    end
  end

  mmb_gpr_ram u_ram (
    .core_clk (core_clk),
    .we       (ram_we),
    .waddr    (ram_idx),
    .wdata    (d_wdata),
    .raddr    (ram_idx),
    .rdata    (ram_rdata)
  );
endmodule
